// *** vit_decoder.sv ***
// Viterbi decoder, K=7, rate one-half, 64-stage traceback
// Notes on behaviour
// [R1] Decodes the K=7 rate one-half code with generators 133 and 171 octal.
// [R2] Two 4-bit soft symbols arrive together, one pair per clock.
// [R3] Survivor traceback walks back 63 trellis stages before a bit is out.
// [R4] A symbol pair and its decoded bit are exactly 267 clocks apart.
// [R5] Reset low forces every flip-flop to its start value at once.
// [R6] All state changes other than reset happen only on the rising edge of the one clock.
// [R7] Start high on a clock edge while idle begins decoding.
// [R8] The upstream logic holds start high for exactly one clock.
// [R9] A running decode ends only by stop or reset; extra starts do nothing.
// [R10] The upstream logic decides when decoding ends and raises stop.
// [R11] The first symbol pair comes in the clock right after start.
// [R12] One decoded bit leaves per clock in steady state.
// [R13] A qualifier marks the clocks in which the decoded bit is taken.
// [R14] Datapath is branch metric, add-compare-select and traceback units.
// [R15] The qualifier stays low after reset until the first bit; start does not clear pairs of an earlier run still in flight.
// [R16] Soft value zero is strongest 0, all ones is strongest 1.
`timescale 1ns/100ps
module vit_decoder
  import vit_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  reset_n,
  input  wire logic                  start,
  input  wire logic                  stop,
  input  wire logic [VIT_SOFT_W-1:0] soft_symbol_first,
  input  wire logic [VIT_SOFT_W-1:0] soft_symbol_second,
  output logic                       decoded_bit,
  output logic                       decoded_bit_valid
);

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic pm_lt(input logic [VIT_PM_W-1:0] a,
                                 input logic [VIT_PM_W-1:0] b);
    logic [VIT_PM_W-1:0] diff;
    diff = a - b;
    return diff[VIT_PM_W-1];
  endfunction

  function automatic logic [1:0] enc_f(input logic u,
                                       input logic [VIT_SW-1:0] p);
    logic [6:0] r;
    r = {u, p};
    return {^(r & VIT_G0), ^(r & VIT_G1)}; // see [R1]
  endfunction

  function automatic logic [VIT_BM_W-1:0] soft_cost(
    input logic [VIT_SOFT_W-1:0] s,
    input logic                  e);
    logic [VIT_SOFT_W-1:0] v;
    v = e ? (VIT_SOFT_MAX - s) : s; // see [R16]
    return {1'b0, v};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Control

  vit_state_t st_q;
  vit_state_t st_d;
  wire logic  go_w;
  wire logic  in_take_w;

  assign go_w = (st_q == VIT_IDLE) && start; // see [R7]
  assign in_take_w = (st_q == VIT_RUN) && !stop; // see [R11]

  always_comb begin
    case (st_q)
      VIT_IDLE: st_d = start ? VIT_RUN : VIT_IDLE; // see [R7]
      VIT_RUN:  st_d = stop ? VIT_IDLE : VIT_RUN; // see [R9]
      default:  st_d = VIT_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin // see [R5] [R6]
    if (!reset_n) begin
      st_q <= VIT_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Branch metric unit

  vit_sym_t                sym_q;
  logic                    sym_v_q;
  logic [VIT_BM_W-1:0]     bm_w [4];

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sym_q   <= '0;
      sym_v_q <= 1'b0;
    end else begin
      sym_v_q <= in_take_w;
      if (in_take_w) begin
        sym_q <= {soft_symbol_first, soft_symbol_second}; // see [R2]
      end
    end
  end

  genvar c;
  generate
    for (c = 0; c < 4; c++) begin : g_bm
      assign bm_w[c] = soft_cost(sym_q.first, 1'(c >> 1))
                     + soft_cost(sym_q.second, 1'(c)); // see [R14]
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Add-compare-select unit

  logic [VIT_PM_W-1:0] pm_q [VIT_NS];
  logic [VIT_PM_W-1:0] pm_d [VIT_NS];
  logic [VIT_NS-1:0]   dec_w;

  genvar s;
  generate
    for (s = 0; s < VIT_NS; s++) begin : g_acs
      localparam logic [VIT_SW-1:0] P0 = 6'((s * 2) % VIT_NS);
      localparam logic [VIT_SW-1:0] P1 = 6'((s * 2 + 1) % VIT_NS);
      localparam logic              U = 1'(s / (VIT_NS / 2));
      localparam logic [VIT_PM_W-1:0] INIT =
        (s == 0) ? VIT_PM_INIT_ZERO : VIT_PM_INIT_OTHER;
      wire logic [VIT_PM_W-1:0] m0_w;
      wire logic [VIT_PM_W-1:0] m1_w;
      assign m0_w = pm_q[P0] + VIT_PM_W'(bm_w[enc_f(U, P0)]);
      assign m1_w = pm_q[P1] + VIT_PM_W'(bm_w[enc_f(U, P1)]);
      assign dec_w[s] = pm_lt(m1_w, m0_w); // see [R14]
      assign pm_d[s] = dec_w[s] ? m1_w : m0_w;

      always_ff @(posedge sys_clk or negedge reset_n) begin // see [R5]
        if (!reset_n) begin
          pm_q[s] <= INIT;
        end else if (go_w) begin
          pm_q[s] <= INIT;
        end else if (sym_v_q) begin
          pm_q[s] <= pm_d[s];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Best state search

  logic [VIT_SW-1:0]   best_w;
  logic [VIT_PM_W-1:0] best_m;

  always_comb begin
    best_w = '0;
    best_m = pm_q[0];
    for (int i = 1; i < VIT_NS; i++) begin
      if (pm_lt(pm_q[i], best_m)) begin
        best_m = pm_q[i];
        best_w = 6'(i);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Traceback unit

  logic [VIT_NS-1:0] hist_q [VIT_TB_DEPTH];
  logic [VIT_SW-1:0] tb_st;
  logic              tb_bit_w;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int k = 0; k < VIT_TB_DEPTH; k++) begin
        hist_q[k] <= '0;
      end
    end else begin
      hist_q[0] <= dec_w;
      for (int k = 1; k < VIT_TB_DEPTH; k++) begin
        hist_q[k] <= hist_q[k-1]; // see [R3]
      end
    end
  end

  always_comb begin
    tb_st = best_w;
    for (int k = 0; k < VIT_TB_DEPTH - 1; k++) begin
      tb_st = {tb_st[VIT_SW-2:0], hist_q[k][tb_st]}; // see [R3]
    end
    tb_bit_w = tb_st[VIT_SW-1];
  end

  ////////////////////////////////////////////////////////////////////////
  // Output alignment

  logic [VIT_BIT_DLY-1:0] bd_q;
  logic [VIT_VLD_DLY-1:0] vld_q;
  logic                   dbit_q;
  logic                   dval_q;

  always_ff @(posedge sys_clk or negedge reset_n) begin // see [R5]
    if (!reset_n) begin
      bd_q   <= '0;
      vld_q  <= '0;
      dbit_q <= 1'b0;
      dval_q <= 1'b0;
    end else begin
      bd_q   <= {bd_q[VIT_BIT_DLY-2:0], tb_bit_w}; // see [R4]
      vld_q  <= {vld_q[VIT_VLD_DLY-2:0], in_take_w}; // see [R4]
      dbit_q <= bd_q[VIT_BIT_DLY-1]; // see [R12]
      dval_q <= vld_q[VIT_VLD_DLY-1]; // see [R13] [R15]
    end
  end

  assign decoded_bit = dbit_q;
  assign decoded_bit_valid = dval_q;

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  AST_START_RUNS: assert property ( // see [R7]
    go_w |=> st_q == VIT_RUN)
    else $error("start while idle did not begin decoding");

  AST_STOP_ENDS: assert property ( // see [R9]
    (st_q == VIT_RUN) && stop |=> st_q == VIT_IDLE && !sym_v_q)
    else $error("stop did not end decoding");

  AST_START_IGNORED: assert property ( // see [R9]
    (st_q == VIT_RUN) && !stop && start |=> st_q == VIT_RUN)
    else $error("start disturbed a running decode");

  AST_LATENCY: assert property ( // see [R4]
    in_take_w |-> ##267 decoded_bit_valid)
    else $error("decoded bit not qualified 267 cycles after its symbols");

  AST_NO_EARLY: assert property ( // see [R15]
    decoded_bit_valid |-> $past(in_take_w, 267))
    else $error("qualifier high with no pair taken 267 cycles before");

  AST_BIT_DELAY: assert property ( // see [R4] [R12]
    vld_q[VIT_VLD_DLY-1] |=> decoded_bit == $past(tb_bit_w, 202))
    else $error("decoded bit not aligned with traceback result");

  AST_TB_DEPTH: assert property ( // see [R3]
    sym_v_q |-> ##64 (hist_q[VIT_TB_DEPTH-1] == $past(dec_w, 64)))
    else $error("survivor history depth is not 64 stages");

  AST_ZERO_PATH: assert property ( // see [R1]
    best_w == '0 && sym_v_q && sym_q == '0 |=> best_w == '0)
    else $error("all-zero path lost on strong zero symbols");

  AST_BM_OFFSET: assert property ( // see [R16]
    sym_v_q |-> bm_w[3] == 5'(2 * VIT_SOFT_MAX) - bm_w[0])
    else $error("branch metrics not offset binary");

  AST_BM_ZERO: assert property ( // see [R16]
    sym_v_q && sym_q == '0 |-> bm_w[0] == '0)
    else $error("strong zero symbols gave a nonzero metric");

  AST_RESET_QUIET: assert property ( // see [R5]
    @(posedge sys_clk) disable iff (1'b0)
    !reset_n ##1 !reset_n |-> !decoded_bit_valid && !decoded_bit
    && st_q == VIT_IDLE)
    else $error("outputs or control not cleared while reset is held");

  AST_IDLE_NO_TAKE: assert property ( // see [R11]
    st_q == VIT_IDLE |=> !sym_v_q)
    else $error("symbol pair taken while idle");

  AST_SYM_HOLD: assert property ( // see [R2] [R11]
    in_take_w |=> sym_v_q
    && sym_q == $past({soft_symbol_first, soft_symbol_second}))
    else $error("taken symbol pair not held for the metric unit");

  AST_PM_RESTART: assert property ( // see [R7]
    go_w |=> pm_q[0] == VIT_PM_INIT_ZERO
    && pm_q[VIT_NS-1] == VIT_PM_INIT_OTHER)
    else $error("path metrics not restarted by start");

  AST_PM_HOLD: assert property ( // see [R9]
    !sym_v_q && !go_w |=> pm_q[0] == $past(pm_q[0]))
    else $error("path metric moved without a symbol pair");

  AST_BEST_LOW: assert property ( // see [R3]
    !pm_lt(pm_q[0], best_m))
    else $error("traceback start is not the best metric state");

  AST_STEADY_STREAM: assert property ( // see [R12]
    sym_v_q && in_take_w |->
    ##267 (decoded_bit_valid && $past(decoded_bit_valid)))
    else $error("contiguous pairs did not give one bit per clock");

  AST_VALID_END: assert property ( // see [R9] [R13]
    (st_q == VIT_RUN) && stop |-> ##267 !decoded_bit_valid)
    else $error("qualifier high for a pair refused at stop");

  ////////////////////////////////////////////////////////////////////////
  // Coverage

  COV_START: cover property (go_w);
  COV_STOP: cover property ((st_q == VIT_RUN) && stop);
  COV_FIRST_OUT: cover property ($rose(decoded_bit_valid));
  COV_START_IGNORED: cover property ((st_q == VIT_RUN) && !stop && start);
  COV_BACK_TO_BACK: cover property ((st_q == VIT_RUN) && stop ##1 go_w);

endmodule // vit_decoder

// *** vit_pkg.sv ***
// Constants and types for the rate one-half Viterbi decoder
package vit_pkg;
  localparam int VIT_SOFT_W = 4;
  localparam int VIT_NS = 64;
  localparam int VIT_SW = 6;
  localparam int VIT_BM_W = 5;
  localparam int VIT_PM_W = 10;
  localparam logic [6:0] VIT_G0 = 7'h5b;
  localparam logic [6:0] VIT_G1 = 7'h79;
  localparam logic [VIT_SOFT_W-1:0] VIT_SOFT_MAX = 4'hf;
  localparam logic [VIT_PM_W-1:0] VIT_PM_INIT_ZERO = 10'h000;
  localparam logic [VIT_PM_W-1:0] VIT_PM_INIT_OTHER = 10'h040;
  localparam int VIT_TB_DEPTH = 64;
  localparam int VIT_LATENCY = 267;
  localparam int VIT_BIT_DLY = VIT_LATENCY - VIT_TB_DEPTH - 2;
  localparam int VIT_VLD_DLY = VIT_LATENCY - 1;

  typedef struct packed {
    logic [VIT_SOFT_W-1:0] first;
    logic [VIT_SOFT_W-1:0] second;
  } vit_sym_t;

  typedef enum {
    VIT_IDLE,
    VIT_RUN
  } vit_state_t;
endpackage

// *** vit_upstream_model.sv ***
// Upstream symbol source: K=7 encoder with soft mapping
`timescale 1ns/100ps
module vit_upstream_model
  import vit_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  send,
  input  wire logic                  data_bit,
  output logic [VIT_SOFT_W-1:0]      soft_symbol_first,
  output logic [VIT_SOFT_W-1:0]      soft_symbol_second
);
  logic [5:0]            hist_q = '0;
  logic                  tog_q = 1'b0;
  logic [1:0]            noise_q = '0;
  logic [6:0]            taps;
  logic [VIT_SOFT_W-1:0] idle_v;
  assign taps = {data_bit, hist_q};
  assign idle_v = {VIT_SOFT_W{tog_q}};
  // Hard code bit with small noise, pattern while idle
  assign soft_symbol_first = !send ? idle_v : ^(taps & VIT_G0) ?
    VIT_SOFT_MAX - noise_q : 4'(noise_q);
  assign soft_symbol_second = !send ? ~idle_v : ^(taps & VIT_G1) ?
    VIT_SOFT_MAX - noise_q : 4'(noise_q);
  ////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk) begin
    hist_q <= send ? {data_bit, hist_q[5:1]} : '0;
    tog_q <= ~tog_q;
    noise_q <= 2'($urandom_range(0, 2));
  end
endmodule // vit_upstream_model

// *** vit_decoder_tb.sv ***
// Self-checking bench for the Viterbi decoder
`timescale 1ns/100ps
module vit_decoder_tb;
  import vit_pkg::*;
  logic                  sys_clk = 0, reset_n = 0, start = 0, stop = 0;
  logic                  send = 0, data_bit = 0, run_q = 0;
  logic [VIT_SOFT_W-1:0] sym_a, sym_b;
  logic                  decoded_bit, decoded_bit_valid;
  int                    failures = 0, n_compared = 0, cyc = 0;
  int                    take_q[$];
  logic [1:0]            bit_q[$];
  logic [1:0]            b;
  always #2 sys_clk = ~sys_clk;
  vit_upstream_model vit_upstream_model_inst (
    .sys_clk            (sys_clk),
    .send               (send),
    .data_bit           (data_bit),
    .soft_symbol_first  (sym_a),
    .soft_symbol_second (sym_b)
  );
  vit_decoder vit_decoder_inst (
    .sys_clk            (sys_clk),
    .reset_n            (reset_n),
    .start              (start),
    .stop               (stop),
    .soft_symbol_first  (sym_a),
    .soft_symbol_second (sym_b),
    .decoded_bit        (decoded_bit),
    .decoded_bit_valid  (decoded_bit_valid)
  );
  ////////////////////////////////////////////////////////////////////
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic close_out();
    $display("Compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  // Reference of taken pairs and expected qualifier timing
  always @(posedge sys_clk) begin
    cyc++;
    if (!reset_n) begin
      run_q <= 0;
      take_q.delete();
    end else begin
      if (run_q && !stop) take_q.push_back(cyc);
      if (stop) run_q <= 0;
      else if (start) run_q <= 1;
    end
    #1;
    if (take_q.size() > 0 && take_q[0] - 1 + VIT_LATENCY == cyc) begin
      check("valid", 1, decoded_bit_valid);
      void'(take_q.pop_front());
      b = bit_q.pop_front();
      if (b[1]) check("bit", b[0], decoded_bit);
    end else begin
      check("valid", 0, decoded_bit_valid);
    end
  end
  always @(posedge sys_clk) if (cyc > 2000) begin
    failures++;
    close_out();
  end
  ////////////////////////////////////////////////////////////////////
  task automatic frame(string name, int n, bit abort);
    @(negedge sys_clk);
    stop = 0;
    start = 1;
    for (int i = 0; i < n; i++) begin
      @(negedge sys_clk);
      start = (i == 5);
      send = 1;
      data_bit = 1'($urandom);
      bit_q.push_back({i < n - VIT_TB_DEPTH, data_bit});
    end
    @(negedge sys_clk);
    send = 0;
    start = 0;
    if (abort) begin
      reset_n = 0;
      #1;
      check("bit_rst", 0, decoded_bit);
      check("valid_rst", 0, decoded_bit_valid);
      bit_q.delete();
      repeat (3) @(negedge sys_clk);
      reset_n = 1;
    end else begin
      stop = 1;
    end
    $display("Test %s done", name);
  endtask
  initial begin
    void'($urandom(92518));
    repeat (20) @(negedge sys_clk);
    reset_n = 1;
    frame("long", 300, 0);
    frame("back_to_back", 70, 0);
    frame("single", 1, 0);
    frame("abort", 100, 1);
    frame("after_reset", 80, 0);
    repeat (300) @(negedge sys_clk);
    check("drained", 0, 32'(take_q.size()));
    close_out();
  end
endmodule // vit_decoder_tb
